/* File: core/coproc_pkg.sv */
// Purpose : Shared constants and types for the two-register coprocessor write link
// Assumes : One clock, one active-low asynchronous reset for both ends
// Notes   : Offsets are byte addresses of the core end's AHB-Lite register window
package coproc_pkg;

  // Register offsets, one aligned word each
  localparam logic [7:0] OFS_INSTR       = 8'h00;
  localparam logic [7:0] OFS_FIRST_VAL   = 8'h04;
  localparam logic [7:0] OFS_SECOND_VAL  = 8'h08;
  localparam logic [7:0] OFS_FLAGS       = 8'h0C;
  localparam logic [7:0] OFS_STATUS      = 8'h10;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h14;
  localparam logic [7:0] OFS_INT_CLEAR   = 8'h18;
  localparam logic [7:0] OFS_INT_ENABLE  = 8'h1C;

  // Instruction word fields
  localparam int COND_LSB       = 28;
  localparam int CLASS_LSB      = 20;
  localparam int SECOND_REG_LSB = 16;
  localparam int FIRST_REG_LSB  = 12;
  localparam int CPNUM_LSB      = 8;
  localparam int OPC_LSB        = 4;
  localparam int CRM_LSB        = 0;
  localparam logic [7:0] DUAL_WRITE_CLASS = 8'hC4;
  localparam logic [3:0] COND_UNCOND      = 4'hF;

  // Flag bits in the flags register
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;

  // Event bits shared by status, clear and enable
  localparam int EV_DONE  = 0;
  localparam int EV_UNDEF = 1;
  localparam int EV_SKIP  = 2;
  localparam int EV_W     = 3;

  // Outcome code in the status register
  localparam logic [1:0] OUT_NONE  = 2'h0;
  localparam logic [1:0] OUT_DONE  = 2'h1;
  localparam logic [1:0] OUT_UNDEF = 2'h2;
  localparam logic [1:0] OUT_SKIP  = 2'h3;

  // Reset values
  localparam logic [31:0]     WORD_RST  = 32'h0000_0000;
  localparam logic [3:0]      FLAGS_RST = 4'h0;
  localparam logic [EV_W-1:0] EV_RST    = 3'h0;

  // Architecture levels and coprocessors mandatory from level 6
  localparam logic [1:0]  ARCH_LEVEL_PRE = 2'h0;
  localparam logic [1:0]  ARCH_LEVEL_5TE = 2'h1;
  localparam logic [1:0]  ARCH_LEVEL_6   = 2'h2;
  localparam logic [15:0] MANDATORY_CP_6 = 16'hC000;

  typedef enum logic [2:0] {
    CORE_IDLE  = 3'h1,
    CORE_OFFER = 3'h2,
    CORE_SEND  = 3'h4
  } core_state_t;

  typedef enum logic [1:0] {
    CP_WAIT = 2'h1,
    CP_TAKE = 2'h2
  } cp_state_t;

endpackage

/* File: core/cp_link_if.sv */
// Purpose : Link between the processor core end and one attached coprocessor
// Assumes : Both ends on the same clock; no clocking block
// Notes   : Several coprocessors would OR their claim, decline and ack lines
`timescale 1ns/10ps
interface cp_link_if;
  logic        offer_valid;
  logic        uncond;
  logic [3:0]  coproc_number_field;
  logic [3:0]  opcode;
  logic [3:0]  crm;
  logic        claim;
  logic        decline;
  logic        first_valid;
  logic [31:0] first_data;
  logic        first_ack;
  logic        second_valid;
  logic [31:0] second_data;
  logic        second_ack;

  modport core_end (
    output offer_valid, uncond, coproc_number_field, opcode, crm,
    output first_valid, first_data, second_valid, second_data,
    input  claim, decline, first_ack, second_ack
  );

  modport coproc_end (
    input  offer_valid, uncond, coproc_number_field, opcode, crm,
    input  first_valid, first_data, second_valid, second_data,
    output claim, decline, first_ack, second_ack
  );
endinterface

/* File: core/cond_eval.sv */
// Purpose : Evaluates a 4-bit condition code against the N Z C V flags
// Assumes : Code 1111 is screened by the caller before this result is used
// Notes   : Pure combinational
`timescale 1ns/10ps
module cond_eval (
  input  wire logic [3:0] cond_i,
  input  wire logic [3:0] flags_i,
  output logic            pass_o
);
  logic n, z, c, v;

  // Split flags
  assign n = flags_i[coproc_pkg::FLAG_N];
  assign z = flags_i[coproc_pkg::FLAG_Z];
  assign c = flags_i[coproc_pkg::FLAG_C];
  assign v = flags_i[coproc_pkg::FLAG_V];

  // Even codes test, odd codes invert, except the always pair
  always_comb begin
    case (cond_i[3:1])
      3'h0:    pass_o = z;
      3'h1:    pass_o = c;
      3'h2:    pass_o = n;
      3'h3:    pass_o = v;
      3'h4:    pass_o = c & ~z;
      3'h5:    pass_o = (n == v);
      3'h6:    pass_o = ~z & (n == v);
      default: pass_o = 1'b1;
    endcase
    if (cond_i[3:1] != 3'h7 && cond_i[0]) begin
      pass_o = ~pass_o;
    end
  end
endmodule

/* File: core/dual_reg_write_core.sv */
// Purpose : Core end of the two-register coprocessor write, driven from AHB-Lite registers
// Assumes : Zero-wait AHB-Lite slave, whole-word accesses, single clock
// Notes   : Writing the instruction register while idle issues the instruction
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
// Operation
// - Condition 1111 always executes, flags ignored
// - Passing condition sends both values; failing sends none
// - Route only to the numbered coprocessor
// - Both values may go in any order
// - Coprocessor decides meaning of both values
// - First source must not be program counter
// - Second source not PC, sources differ
// - Only bits 31..8 fixed; low byte advisory
// - Pass opcode and register fields uninterpreted
// - Coprocessors 14 and 15 mandatory from level 6
// - Unimplemented coprocessor instructions raise undefined exception
// - Conditional from 5TE, unconditional from level 6
// - No coprocessor claims: undefined exception
module dual_reg_write_core #(
  parameter logic [1:0]  ARCH_LEVEL = coproc_pkg::ARCH_LEVEL_6,
  parameter logic [15:0] CP_PRESENT = 16'hFFFF
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic             HREADYOUT_O,
  output logic [31:0]      HRDATA_O,
  output logic             HRESP_O,
  output logic             IRQ_O,
  cp_link_if.core_end      link
);
  localparam int EW = coproc_pkg::EV_W;

  coproc_pkg::core_state_t state_r, state_nxt;
  logic [31:0]   instr_r, instr_nxt;
  logic [31:0]   first_r, first_nxt;
  logic [31:0]   second_r, second_nxt;
  logic [3:0]    flags_r, flags_nxt;
  logic [EW-1:0] int_en_r, int_en_nxt;
  logic [EW-1:0] int_stat_r, int_stat_nxt;
  logic [1:0]    outcome_r, outcome_nxt;
  logic          first_done_r, first_done_nxt;
  logic          second_done_r, second_done_nxt;
  logic          wr_pend_r, wr_pend_nxt;
  logic [7:0]    addr_r, addr_nxt;
  logic [31:0]   hrdata_r, hrdata_nxt;
  logic          take;
  logic          start;
  logic [EW-1:0] ev;
  logic [EW-1:0] clr;
  logic [15:0]   present;
  logic [3:0]    cond;
  logic [3:0]    cpn;
  logic          uncond;
  logic          cond_pass;
  logic          supported;
  logic          legal;
  logic          first_end;
  logic          second_end;

  // Write decode in the data phase, shared by every writable register
  function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = pend && (a == ofs);
  endfunction

  // Read mux; unmapped and write-only offsets read as zero
  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = 32'h0000_0000;
    case (a)
      coproc_pkg::OFS_INSTR:      read_word = instr_r;
      coproc_pkg::OFS_FIRST_VAL:  read_word = first_r;
      coproc_pkg::OFS_SECOND_VAL: read_word = second_r;
      coproc_pkg::OFS_FLAGS:      read_word = {28'h000_0000, flags_r};
      coproc_pkg::OFS_STATUS:     read_word = {29'h0000_0000, outcome_r, state_r != coproc_pkg::CORE_IDLE};
      coproc_pkg::OFS_INT_STATUS: read_word = {29'h0000_0000, int_stat_r};
      coproc_pkg::OFS_INT_ENABLE: read_word = {29'h0000_0000, int_en_r};
      default:                    read_word = 32'h0000_0000;
    endcase
  endfunction

  // Coprocessors 14 and 15 count as present from level 6 on
  assign present = CP_PRESENT | ((ARCH_LEVEL >= coproc_pkg::ARCH_LEVEL_6) ?
                   coproc_pkg::MANDATORY_CP_6 : 16'h0000);

  // Decode the instruction word as it is written
  assign cond   = HWDATA_I[coproc_pkg::COND_LSB +: 4];
  assign cpn    = HWDATA_I[coproc_pkg::CPNUM_LSB +: 4];
  assign uncond = (cond == coproc_pkg::COND_UNCOND);

  cond_eval u_cond (
    .cond_i  (cond),
    .flags_i (flags_r),
    .pass_o  (cond_pass)
  );

  // Variant availability by architecture level
  assign supported = uncond ? (ARCH_LEVEL >= coproc_pkg::ARCH_LEVEL_6)
                            : (ARCH_LEVEL >= coproc_pkg::ARCH_LEVEL_5TE);
  // Wrong class, missing variant or absent coprocessor is undefined
  assign legal = (HWDATA_I[coproc_pkg::CLASS_LSB +: 8] == coproc_pkg::DUAL_WRITE_CLASS)
                 && supported && present[cpn];

  // AHB-Lite address phase capture; the slave never inserts wait states
  always_comb begin
    take        = HSEL_I && HTRANS_I[1] && HREADY_I;
    wr_pend_nxt = take && HWRITE_I;
    addr_nxt    = take ? HADDR_I[7:0] : addr_r;
    hrdata_nxt  = (take && !HWRITE_I) ? read_word(HADDR_I[7:0]) : hrdata_r;
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      hrdata_r  <= coproc_pkg::WORD_RST;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      addr_r    <= addr_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = hrdata_r;

  // Issue sequencer; an instruction write while busy is dropped, software polls STATUS first
  always_comb begin
    state_nxt       = state_r;
    instr_nxt       = instr_r;
    first_done_nxt  = first_done_r;
    second_done_nxt = second_done_r;
    outcome_nxt     = outcome_r;
    ev              = coproc_pkg::EV_RST;
    start           = wr_hit(wr_pend_r, addr_r, coproc_pkg::OFS_INSTR) && (state_r == coproc_pkg::CORE_IDLE);
    first_end       = first_done_r || link.first_ack;
    second_end      = second_done_r || link.second_ack;
    case (state_r)
      coproc_pkg::CORE_IDLE: begin
        if (start) begin
          instr_nxt = HWDATA_I;
          if (!legal) begin
            ev[coproc_pkg::EV_UNDEF] = 1'b1;
            outcome_nxt              = coproc_pkg::OUT_UNDEF;
          end else if (!uncond && !cond_pass) begin
            ev[coproc_pkg::EV_SKIP] = 1'b1;
            outcome_nxt             = coproc_pkg::OUT_SKIP;
          end else begin
            state_nxt = coproc_pkg::CORE_OFFER;
          end
        end
      end
      coproc_pkg::CORE_OFFER: begin
        if (link.claim) begin
          state_nxt       = coproc_pkg::CORE_SEND;
          first_done_nxt  = 1'b0;
          second_done_nxt = 1'b0;
        end else if (link.decline) begin
          state_nxt                = coproc_pkg::CORE_IDLE;
          ev[coproc_pkg::EV_UNDEF] = 1'b1;
          outcome_nxt              = coproc_pkg::OUT_UNDEF;
        end
      end
      coproc_pkg::CORE_SEND: begin
        first_done_nxt  = first_end;
        second_done_nxt = second_end;
        if (first_end && second_end) begin
          state_nxt               = coproc_pkg::CORE_IDLE;
          ev[coproc_pkg::EV_DONE] = 1'b1;
          outcome_nxt             = coproc_pkg::OUT_DONE;
        end
      end
      default: begin
        state_nxt = coproc_pkg::CORE_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_r       <= coproc_pkg::CORE_IDLE;
      instr_r       <= coproc_pkg::WORD_RST;
      first_done_r  <= 1'b0;
      second_done_r <= 1'b0;
      outcome_r     <= coproc_pkg::OUT_NONE;
    end else begin
      state_r       <= state_nxt;
      instr_r       <= instr_nxt;
      first_done_r  <= first_done_nxt;
      second_done_r <= second_done_nxt;
      outcome_r     <= outcome_nxt;
    end
  end

  // Software registers; operand words stay writable while busy but feed the link directly, so the next issue is staged only once idle
  always_comb begin
    first_nxt    = wr_hit(wr_pend_r, addr_r, coproc_pkg::OFS_FIRST_VAL) ? HWDATA_I : first_r;
    second_nxt   = wr_hit(wr_pend_r, addr_r, coproc_pkg::OFS_SECOND_VAL) ? HWDATA_I : second_r;
    flags_nxt    = wr_hit(wr_pend_r, addr_r, coproc_pkg::OFS_FLAGS) ? HWDATA_I[3:0] : flags_r;
    int_en_nxt   = wr_hit(wr_pend_r, addr_r, coproc_pkg::OFS_INT_ENABLE) ? HWDATA_I[EW-1:0] : int_en_r;
    clr          = wr_hit(wr_pend_r, addr_r, coproc_pkg::OFS_INT_CLEAR) ? HWDATA_I[EW-1:0] : coproc_pkg::EV_RST;
    int_stat_nxt = (int_stat_r & ~clr) | ev; // A new event beats a clear in the same cycle
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      first_r    <= coproc_pkg::WORD_RST;
      second_r   <= coproc_pkg::WORD_RST;
      flags_r    <= coproc_pkg::FLAGS_RST;
      int_en_r   <= coproc_pkg::EV_RST;
      int_stat_r <= coproc_pkg::EV_RST;
    end else begin
      first_r    <= first_nxt;
      second_r   <= second_nxt;
      flags_r    <= flags_nxt;
      int_en_r   <= int_en_nxt;
      int_stat_r <= int_stat_nxt;
    end
  end

  assign IRQ_O = |(int_stat_r & int_en_r);

  // Link drive; operand words are the staged registers, which must stay put while busy
  assign link.offer_valid         = (state_r == coproc_pkg::CORE_OFFER);
  assign link.uncond              = (instr_r[coproc_pkg::COND_LSB +: 4] == coproc_pkg::COND_UNCOND);
  assign link.coproc_number_field = instr_r[coproc_pkg::CPNUM_LSB +: 4];
  assign link.opcode              = instr_r[coproc_pkg::OPC_LSB +: 4];
  assign link.crm                 = instr_r[coproc_pkg::CRM_LSB +: 4];
  assign link.first_valid         = (state_r == coproc_pkg::CORE_SEND) && !first_done_r;
  assign link.second_valid        = (state_r == coproc_pkg::CORE_SEND) && !second_done_r;
  assign link.first_data          = first_r;
  assign link.second_data         = second_r;
endmodule

/* File: core/dual_reg_write_coproc.sv */
// Purpose : Coprocessor end that accepts the two-register write
// Assumes : Same clock as the core end; one coprocessor on the link
// Notes   : TAKE_READY_I low stalls both acknowledges
`timescale 1ns/10ps
module dual_reg_write_coproc #(
  parameter logic [3:0] CP_NUMBER = 4'hA,
  parameter bit         SUPPORTS  = 1'b1
) (
  input  wire logic   CORE_CLK_I,
  input  wire logic   RESET_N_I,
  input  wire logic   TAKE_READY_I,
  cp_link_if.coproc_end link,
  output logic        WRITE_STROBE_O,
  output logic [31:0] FIRST_WORD_O,
  output logic [31:0] SECOND_WORD_O,
  output logic [3:0]  OPCODE_O,
  output logic [3:0]  CRM_O,
  output logic        UNCOND_O
);
  coproc_pkg::cp_state_t state_r, state_nxt;
  logic        got1_r, got1_nxt;
  logic        got2_r, got2_nxt;
  logic [31:0] w1_r, w1_nxt;
  logic [31:0] w2_r, w2_nxt;
  logic [3:0]  opc_r, opc_nxt;
  logic [3:0]  crm_r, crm_nxt;
  logic        unc_r, unc_nxt;
  logic        strobe_r, strobe_nxt;
  logic        mine;

  // Claim only our own number, and only if this variant is built in
  assign mine         = (link.coproc_number_field == CP_NUMBER) && SUPPORTS;
  assign link.claim   = (state_r == coproc_pkg::CP_WAIT) && link.offer_valid && mine;
  assign link.decline = (state_r == coproc_pkg::CP_WAIT) && link.offer_valid && !mine;
  // Either word is taken once it shows while TAKE_READY_I is high, in whatever order
  assign link.first_ack  = (state_r == coproc_pkg::CP_TAKE) && link.first_valid && !got1_r && TAKE_READY_I;
  assign link.second_ack = (state_r == coproc_pkg::CP_TAKE) && link.second_valid && !got2_r && TAKE_READY_I;

  // Capture fields on claim, words on their acks, strobe once both are in
  always_comb begin
    state_nxt  = state_r;
    got1_nxt   = got1_r;
    got2_nxt   = got2_r;
    w1_nxt     = link.first_ack ? link.first_data : w1_r;
    w2_nxt     = link.second_ack ? link.second_data : w2_r;
    opc_nxt    = opc_r;
    crm_nxt    = crm_r;
    unc_nxt    = unc_r;
    strobe_nxt = 1'b0;
    case (state_r)
      coproc_pkg::CP_WAIT: begin
        if (link.claim) begin
          state_nxt = coproc_pkg::CP_TAKE;
          got1_nxt  = 1'b0;
          got2_nxt  = 1'b0;
          opc_nxt   = link.opcode; // Meaning of opcode and crm is ours alone
          crm_nxt   = link.crm;
          unc_nxt   = link.uncond;
        end
      end
      coproc_pkg::CP_TAKE: begin
        got1_nxt = got1_r || link.first_ack;
        got2_nxt = got2_r || link.second_ack;
        if (got1_nxt && got2_nxt) begin
          state_nxt  = coproc_pkg::CP_WAIT;
          strobe_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = coproc_pkg::CP_WAIT;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_r  <= coproc_pkg::CP_WAIT;
      got1_r   <= 1'b0;
      got2_r   <= 1'b0;
      w1_r     <= coproc_pkg::WORD_RST;
      w2_r     <= coproc_pkg::WORD_RST;
      opc_r    <= 4'h0;
      crm_r    <= 4'h0;
      unc_r    <= 1'b0;
      strobe_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      got1_r   <= got1_nxt;
      got2_r   <= got2_nxt;
      w1_r     <= w1_nxt;
      w2_r     <= w2_nxt;
      opc_r    <= opc_nxt;
      crm_r    <= crm_nxt;
      unc_r    <= unc_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  assign WRITE_STROBE_O = strobe_r;
  assign FIRST_WORD_O   = w1_r;
  assign SECOND_WORD_O  = w2_r;
  assign OPCODE_O       = opc_r;
  assign CRM_O          = crm_r;
  assign UNCOND_O       = unc_r;
endmodule

/* File: testbench/dual_register_coproc_write_chk.sv */
// Purpose : Concurrent checks on the core-to-coprocessor link
// Assumes : One clock and one active-low reset for both ends
// Notes   : Instantiated beside the link, no bind
`timescale 1ns/10ps
module dual_register_coproc_write_chk #(
  parameter logic [3:0] CP_NUMBER = 4'hA
) (
  input wire logic        CORE_CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        offer_valid,
  input wire logic        uncond,
  input wire logic [3:0]  coproc_number_field,
  input wire logic [3:0]  opcode,
  input wire logic [3:0]  crm,
  input wire logic        claim,
  input wire logic        decline,
  input wire logic        first_valid,
  input wire logic [31:0] first_data,
  input wire logic        first_ack,
  input wire logic        second_valid,
  input wire logic [31:0] second_data,
  input wire logic        second_ack
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // Words must wait for their ack unchanged
  a_first_word_hold: assert property (first_valid && !first_ack |=> first_valid && $stable(first_data))
    else $error("first word moved before ack");
  a_second_word_hold: assert property (second_valid && !second_ack |=>
    second_valid && $stable(second_data))
    else $error("second word moved before ack");
  // The far end answers at once, so the fields are checked one cycle past the offer too
  a_offer_fields_hold: assert property (offer_valid |=>
    $stable({uncond, coproc_number_field, opcode, crm}) && (offer_valid || $past(claim || decline)))
    else $error("offer changed before answer");
  a_claim_sends_both: assert property (offer_valid && claim |=>
    first_valid && second_valid && !offer_valid)
    else $error("claim not followed by both words");
  a_decline_sends_none: assert property (offer_valid && decline |=>
    !offer_valid ##0 !(first_valid || second_valid))
    else $error("decline still led to a transfer");
  a_send_needs_claim: assert property ($rose(first_valid) |-> $past(claim))
    else $error("words sent without a claim");
  a_claim_own_number: assert property (offer_valid && claim |-> coproc_number_field == CP_NUMBER)
    else $error("claim for another coprocessor number");
  a_offer_answered: assert property ($rose(offer_valid) |-> claim || decline)
    else $error("offer left without claim or decline");
  a_no_offer_overlap: assert property (first_valid || second_valid |-> !offer_valid)
    else $error("new offer while words pending");
endmodule

/* File: testbench/dual_register_coproc_write_tb.sv */
// Purpose : Self-checking bench for both ends of the two-register coprocessor write
// Assumes : Zero-wait slave, one coprocessor numbered A on the link
// Notes   : Random stalls on the coprocessor side exercise the hold rules
`timescale 1ns/10ps
module dual_register_coproc_write_tb;
  logic        clk, rst_n, take_ready, stall, hwrite, hready, hresp, irq, strobe, unc;
  logic [1:0]  htrans;
  logic [3:0]  opc, crm;
  logic [31:0] haddr, hwdata, hrdata, rd, w1, w2, cur, fw, sw;
  logic [72:0] expq[$];
  int          errors, n_compared, seed;

  cp_link_if link();
  dual_reg_write_core i_dual_reg_write_core (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(1'b1),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HREADYOUT_O(hready), .HRDATA_O(hrdata), .HRESP_O(hresp), .IRQ_O(irq), .link(link));
  dual_reg_write_coproc i_dual_reg_write_coproc (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .TAKE_READY_I(take_ready), .link(link), .WRITE_STROBE_O(strobe), .FIRST_WORD_O(fw),
    .SECOND_WORD_O(sw), .OPCODE_O(opc), .CRM_O(crm), .UNCOND_O(unc));
  dual_register_coproc_write_chk i_chk (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .offer_valid(link.offer_valid), .uncond(link.uncond), .coproc_number_field(link.coproc_number_field),
    .opcode(link.opcode), .crm(link.crm), .claim(link.claim), .decline(link.decline),
    .first_valid(link.first_valid), .first_data(link.first_data), .first_ack(link.first_ack),
    .second_valid(link.second_valid), .second_data(link.second_data), .second_ack(link.second_ack));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Random acceptance; stall blocks it to hold transfers open
  always @(posedge clk) begin
    take_ready <= !stall && (($random(seed) & 3) != 0);
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [72:0] seen, input logic [72:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: bus wait ran out", $time);
      tally_and_finish();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task automatic irq_is(input logic v);
    @(negedge clk);
    chk(irq, v);
    @(posedge clk);
  endtask

  // Flags are N Z C V from bit 3 down; odd codes invert the even one, except 1111 which passes like 1110
  function automatic bit pass(input logic [3:0] c, input logic [3:0] f);
    bit b;
    case (c[3:1])
      3'h0: b = f[2];
      3'h1: b = f[1];
      3'h2: b = f[3];
      3'h3: b = f[0];
      3'h4: b = f[1] & !f[2];
      3'h5: b = f[3] == f[0];
      3'h6: b = !f[2] & (f[3] == f[0]);
      default: b = !c[0];
    endcase
    return b ^ c[0];
  endfunction

  task automatic run(input logic [3:0] cond, input logic [7:0] cls, input logic [3:0] cp, input bit hold,
                     input bit ie);
    logic [3:0] fl;
    logic [1:0] oc;
    int         n;
    fl = 4'($random(seed));
    w1 = $random(seed);
    w2 = $random(seed);
    cur = $random(seed);
    cur[31:20] = {cond, cls};
    cur[11:8] = cp;
    // Software keeps the program counter out and the two sources apart
    cur[19:16] = {1'b0, cur[18:16]};
    cur[15:12] = {1'b1, cur[14:13], 1'b0};
    if (cls !== coproc_pkg::DUAL_WRITE_CLASS) oc = coproc_pkg::OUT_UNDEF;
    else if (cond != 4'hF && !pass(cond, fl)) oc = coproc_pkg::OUT_SKIP;
    else if (cp != 4'hA) oc = coproc_pkg::OUT_UNDEF;
    else begin
      oc = coproc_pkg::OUT_DONE;
      expq.push_back({cond == 4'hF, cur[7:0], w1, w2});
    end
    ahb(1'b1, coproc_pkg::OFS_FIRST_VAL, w1);
    ahb(1'b1, coproc_pkg::OFS_SECOND_VAL, w2);
    ahb(1'b1, coproc_pkg::OFS_FLAGS, {28'h000_0000, fl});
    ahb(1'b1, coproc_pkg::OFS_INSTR, cur);
    if (hold) begin
      ahb(1'b1, coproc_pkg::OFS_INSTR, ~cur);
      ahb(1'b0, coproc_pkg::OFS_STATUS, 32'h0000_0000);
      chk(rd[0], 1'b1);
      stall <= 1'b0;
    end
    n = 0;
    do begin
      ahb(1'b0, coproc_pkg::OFS_STATUS, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 64);
    chk(rd, {29'h0000_0000, oc, 1'b0});
    rdchk(coproc_pkg::OFS_INT_STATUS, 32'h0000_0001 << (oc - 2'h1));
    irq_is(ie);
    ahb(1'b1, coproc_pkg::OFS_INT_CLEAR, 32'h0000_0007);
    irq_is(1'b0);
  endtask

  // Watch the coprocessor's captures and the link fields
  always @(negedge clk) begin
    if (strobe === 1'b1) begin
      if (expq.size() == 0) begin
        errors++;
        $display("unexpected at %0t: stray write strobe", $time);
      end else chk({unc, opc, crm, fw, sw}, expq.pop_front());
    end
    if (link.offer_valid === 1'b1)
      chk({link.uncond, link.coproc_number_field, link.opcode, link.crm}, {cur[31:28] == 4'hF, cur[11:0]});
    if (link.first_valid === 1'b1) chk({link.first_data, link.second_data}, {w1, w2});
  end

  initial begin
    seed = 2321;
    {stall, htrans, haddr, hwrite, hwdata, rst_n} = '0;
    errors = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(coproc_pkg::OFS_STATUS, 32'h0000_0000);
    rdchk(coproc_pkg::OFS_INT_STATUS, 32'h0000_0000);
    rdchk(8'h40, 32'h0000_0000);
    ahb(1'b1, coproc_pkg::OFS_INT_ENABLE, 32'h0000_0007);
    rdchk(coproc_pkg::OFS_INT_ENABLE, 32'h0000_0007);
    rdchk(coproc_pkg::OFS_INT_CLEAR, 32'h0000_0000);
    $display("test registers done");
    for (int c = 0; c < 16; c++) run(c[3:0], 8'hC4, 4'hA, 1'b0, 1'b1);
    $display("test conditions done");
    run(4'hF, 8'hC4, 4'h5, 1'b0, 1'b1);
    run(4'hE, 8'hC5, 4'hA, 1'b0, 1'b1);
    $display("test refusals done");
    stall <= 1'b1;
    run(4'hF, 8'hC4, 4'hA, 1'b1, 1'b1);
    $display("test stall done");
    ahb(1'b1, coproc_pkg::OFS_INT_ENABLE, 32'h0000_0005);
    run(4'hE, 8'hC4, 4'h5, 1'b0, 1'b0);
    $display("test masking done");
    chk(expq.size(), 73'h0);
    tally_and_finish();
  end
endmodule
